// file: ubtx_map.svh
// register map, field positions and timing constants of the upstream burst transmitter
// What this block does
// - stages run in order: block, FEC, scramble, preamble, map, filter, timed modulate
// - packet bytes are cut into blocks of one codeword's information bytes
// - each block is Reed-Solomon encoded; last block may be a shortened codeword
// - FEC can be switched off; the whole packet then goes to scrambler as one block without parity
// - stream is mapped into QPSK or 16QAM symbols after scramble and preamble
// - mapped symbols pass a spectral shaping filter before the modulator output
// - each burst starts at a scheduled time; QPSK or 16QAM is selectable
// - five symbol rates are selectable: 160, 320, 640, 1280 and 2560 ksym/s
// - a shortened last codeword holds at least 16 bytes, else it is not sent
// - fixed mode pads the last codeword with zeros, then sends zero codewords
`ifndef UBTX_MAP_SVH
`define UBTX_MAP_SVH
`define UBTX_A_CTRL 8'h00
`define UBTX_A_CW 8'h04
`define UBTX_A_PKT 8'h08
`define UBTX_A_GRANT 8'h0c
`define UBTX_A_START 8'h10
`define UBTX_A_PRE 8'h14
`define UBTX_A_PCFG 8'h18
`define UBTX_A_DATA 8'h1c
`define UBTX_A_STAT 8'h20
`define UBTX_A_TIME 8'h24
`define UBTX_F_FEC 0
`define UBTX_F_SHORT 1
`define UBTX_F_M16 2
`define UBTX_F_RATE 6:4
`define UBTX_F_GO 8
`define UBTX_F_PLEN 7:0
`define UBTX_F_SEED 30:16
`define UBTX_S_BUSY 0
`define UBTX_S_WAIT 1
`define UBTX_S_UNDER 2
`define UBTX_S_DONE 3
`define UBTX_S_SPACE 4
`define UBTX_K_RST 8'h10
`define UBTX_SEED_RST 15'h1529
`define UBTX_RATE_MAX 3'h4
`define UBTX_RS_T 4
`define UBTX_NPAR (2 * `UBTX_RS_T)
`define UBTX_GF_POLY 8'h1d
`define UBTX_MIN_SHORT 16'h0010
`define UBTX_BASE_RATE_SPS 160000
`define UBTX_CLK_HZ 25000000
`define UBTX_FIR_C0 8'h01
`define UBTX_FIR_C1 8'h03
`define UBTX_FLUSH 3'h3
`define UBTX_FIFO_W 8
`define UBTX_FIFO_D 16
`define UBTX_OKAY 2'b00
`define UBTX_SLVERR 2'b10
`endif

// file: ubtx_pkg.sv
// types and Galois-field helpers of the upstream burst transmitter
`include "ubtx_map.svh"
package ubtx_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_PRE, ST_NEXT, ST_INFO, ST_PAR, ST_FLUSH} ubtx_ph_t;
   typedef logic [`UBTX_NPAR-1:0][7:0] ubtx_par_t;

   // multiply in GF(256)
   function automatic logic [7:0] ubtx_gf_mul(input logic [7:0] x, input logic [7:0] y);
      logic [7:0] p;
      logic [7:0] a;
      p = '0;
      a = x;
      for (int i = 0; i < 8; i++) begin
         if (y[i]) p = p ^ a;
         a = a[7] ? ({a[6:0], 1'b0} ^ `UBTX_GF_POLY) : {a[6:0], 1'b0};
      end
      return p;
   endfunction

   // generator polynomial, roots alpha^0 .. alpha^(npar-1), leading one implied
   function automatic ubtx_par_t ubtx_gen();
      logic [`UBTX_NPAR:0][7:0] g;
      logic [7:0] a;
      g = '0;
      g[0] = 8'h01;
      a = 8'h01;
      for (int i = 0; i < `UBTX_NPAR; i++) begin
         for (int j = `UBTX_NPAR; j > 0; j--) g[j] = g[j-1] ^ ubtx_gf_mul(g[j], a);
         g[0] = ubtx_gf_mul(g[0], a);
         a = ubtx_gf_mul(a, 8'h02);
      end
      return g[`UBTX_NPAR-1:0];
   endfunction
endpackage

// file: ubtx_fifo.sv
// byte fifo with registered read data between bus writes and the burst engine
`timescale 1ns/100ps
`default_nettype none
module ubtx_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, low
   input wire logic in_valid, // write offer
   input wire logic [W-1:0] in_data, // write word
   output logic in_ready, // room left
   output logic out_valid, // read word present
   output logic [W-1:0] out_data, // read word
   input wire logic out_ready // reader takes word
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic [W-1:0] od;
      logic ir;
   } ubtx_fst_t;
   ubtx_fst_t s;
   ubtx_fst_t n;
   logic push;
   logic pop;

   // next state: store, move to output register, count
   always_comb begin
      n = s;
      push = in_valid & s.ir;
      pop = (s.cnt != '0) & (~s.ov | out_ready);
      if (s.ov && out_ready) n.ov = 1'b0;
      if (pop) begin
         n.od = s.mem[s.rp];
         n.ov = 1'b1;
         n.rp = AW'(s.rp + 1'b1);
      end
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp = AW'(s.wp + 1'b1);
      end
      n.cnt = (AW+1)'(s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
      n.ir = n.cnt < (AW+1)'(D);
   end

   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) s <= '0;
      else s <= n;
   end

   assign in_ready = s.ir;
   assign out_valid = s.ov;
   assign out_data = s.od;
endmodule
`default_nettype wire

// file: ubtx_top.sv
// upstream burst transmitter: bus registers, framing, fec, scrambler, mapper, filter, timing
`timescale 1ns/100ps
`default_nettype none
`include "ubtx_map.svh"
module ubtx_top
   import ubtx_pkg::*;
(
   input wire logic aclk, // 25 MHz clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [31:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   output logic [1:0] bresp, // write response
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic [7:0] araddr, // read address
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   output logic [31:0] rdata, // read data
   output logic [1:0] rresp, // read response
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [7:0] tx_i, // shaped in-phase sample
   output logic [7:0] tx_q, // shaped quadrature sample
   output logic tx_strobe, // one pulse per symbol
   output logic tx_burst // burst on air
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic aw_have;
      logic w_have;
      logic [7:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic fec_en;
      logic short_mode;
      logic m16;
      logic [2:0] rate;
      logic [7:0] k;
      logic [15:0] pkt_len;
      logic [15:0] grant;
      logic [31:0] start_time;
      logic [31:0] pre_pat;
      logic [7:0] pre_len;
      logic [14:0] seed;
      logic underrun;
      logic done;
      logic [31:0] now;
      logic [31:0] acc;
      ubtx_ph_t ph;
      logic [15:0] pkt_left;
      logic [15:0] grant_left;
      logic [15:0] info_left;
      logic [7:0] pre_cnt;
      logic [1:0] pre_idx;
      logic [3:0] par_cnt;
      logic first_cw;
      logic [14:0] lfsr;
      ubtx_par_t par;
      logic [7:0] sh;
      logic [3:0] nbits;
      logic [2:0] flush_cnt;
      logic [2:0][3:0] hi;
      logic [2:0][3:0] hq;
      logic [7:0] tx_i;
      logic [7:0] tx_q;
      logic tx_strobe;
      logic tx_burst;
   } ubtx_st_t;

   localparam ubtx_par_t GEN = ubtx_gen();

   ubtx_st_t s;
   ubtx_st_t n;
   logic fin_valid;
   logic fin_ready;
   logic fout_valid;
   logic [7:0] fout_data;
   logic fout_ready;
   logic tick;
   logic take;
   logic [7:0] d;
   logic [7:0] sb;
   logic [7:0] fb;
   logic [15:0] len;
   logic [3:0] li;
   logic [3:0] lq;

   // symbol clock increment for a rate index, 160 ksym/s doubled per step
   function automatic logic [31:0] nco_inc(input logic [2:0] r);
      logic [63:0] v;
      v = ((64'(`UBTX_BASE_RATE_SPS) << r) << 32) / 64'(`UBTX_CLK_HZ);
      return v[31:0];
   endfunction

   // scramble one byte msb first, x^15+x^14+1, returns {state, byte}
   function automatic logic [22:0] scr(input logic [14:0] l, input logic [7:0] b);
      logic f;
      logic [7:0] o;
      o = '0;
      for (int i = 7; i >= 0; i--) begin
         f = l[14] ^ l[13];
         o[i] = b[i] ^ f;
         l = {l[13:0], f};
      end
      return {l, o};
   endfunction

   // two gray bits to a signed level: 00 +3, 01 +1, 11 -1, 10 -3
   function automatic logic [3:0] lvl2(input logic b1, input logic b0);
      case ({b1, b0})
         2'b00: return 4'h3;
         2'b01: return 4'h1;
         2'b11: return 4'hf;
         default: return 4'hd;
      endcase
   endfunction

   // four-tap symmetric shaping filter on signed levels
   function automatic logic [7:0] fir(input logic [3:0] x0, input logic [2:0][3:0] h);
      logic [7:0] a;
      logic [7:0] b;
      a = 8'({{4{x0[3]}}, x0} + {{4{h[2][3]}}, h[2]});
      b = 8'({{4{h[0][3]}}, h[0]} + {{4{h[1][3]}}, h[1]});
      return 8'(a * `UBTX_FIR_C0 + b * `UBTX_FIR_C1);
   endfunction

   // information length of the next codeword, zero ends the burst
   function automatic logic [15:0] cw_len(input ubtx_st_t t);
      logic [15:0] m;
      m = (t.grant_left < {8'h00, t.k}) ? t.grant_left : {8'h00, t.k};
      if (!t.fec_en) return t.first_cw ? t.pkt_left : 16'h0000;
      if (t.short_mode) return (m >= `UBTX_MIN_SHORT) ? m : 16'h0000;
      return (t.k != 8'h00 && t.grant_left >= {8'h00, t.k}) ? {8'h00, t.k} : 16'h0000;
   endfunction

   ubtx_fifo #(
      .W(`UBTX_FIFO_W),
      .D(`UBTX_FIFO_D)
   ) i_ubtx_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(fin_valid),
      .in_data(s.wdata[7:0]),
      .in_ready(fin_ready),
      .out_valid(fout_valid),
      .out_data(fout_data),
      .out_ready(fout_ready)
   );

   always_comb begin
      n = s;
      fin_valid = 1'b0;
      fout_ready = 1'b0;
      tick = 1'b0;
      take = 1'b0;
      d = '0;
      sb = '0;
      fb = '0;
      len = '0;
      li = '0;
      lq = '0;
      n.tx_strobe = 1'b0;

      // write channels: take address and data in either order
      if (awvalid && s.awready) begin
         n.aw_have = 1'b1;
         n.waddr = awaddr;
      end
      if (wvalid && s.wready) begin
         n.w_have = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      fin_valid = s.aw_have & s.w_have & ~s.bvalid & (s.waddr == `UBTX_A_DATA) & s.wstrb[0];
      if (s.aw_have && s.w_have && !s.bvalid &&
          (s.waddr != `UBTX_A_DATA || !s.wstrb[0] || fin_ready)) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = `UBTX_OKAY;
         case (s.waddr)
            `UBTX_A_CTRL: begin
               n.fec_en = s.wdata[`UBTX_F_FEC];
               n.short_mode = s.wdata[`UBTX_F_SHORT];
               n.m16 = s.wdata[`UBTX_F_M16];
               n.rate = (s.wdata[`UBTX_F_RATE] > `UBTX_RATE_MAX) ? `UBTX_RATE_MAX :
                        s.wdata[`UBTX_F_RATE];
               if (s.wdata[`UBTX_F_GO] && s.ph == ST_IDLE) n.ph = ST_WAIT;
            end
            `UBTX_A_CW: n.k = s.wdata[7:0];
            `UBTX_A_PKT: n.pkt_len = s.wdata[15:0];
            `UBTX_A_GRANT: n.grant = s.wdata[15:0];
            `UBTX_A_START: n.start_time = s.wdata;
            `UBTX_A_PRE: n.pre_pat = s.wdata;
            `UBTX_A_PCFG: begin
               n.pre_len = s.wdata[`UBTX_F_PLEN];
               n.seed = s.wdata[`UBTX_F_SEED];
            end
            `UBTX_A_STAT: begin
               if (s.wdata[`UBTX_S_UNDER]) n.underrun = 1'b0;
               if (s.wdata[`UBTX_S_DONE]) n.done = 1'b0;
            end
            `UBTX_A_DATA, `UBTX_A_TIME: ;
            default: n.bresp = `UBTX_SLVERR;
         endcase
      end
      if (s.bvalid && bready) n.bvalid = 1'b0;
      n.awready = ~n.aw_have & ~n.bvalid;
      n.wready = ~n.w_have & ~n.bvalid;

      // read channel: answer in the cycle after the address is taken
      if (s.rvalid && rready) n.rvalid = 1'b0;
      if (arvalid && s.arready) begin
         n.rvalid = 1'b1;
         n.rresp = `UBTX_OKAY;
         n.rdata = '0;
         case (araddr)
            `UBTX_A_CTRL: begin
               n.rdata[`UBTX_F_FEC] = s.fec_en;
               n.rdata[`UBTX_F_SHORT] = s.short_mode;
               n.rdata[`UBTX_F_M16] = s.m16;
               n.rdata[`UBTX_F_RATE] = s.rate;
            end
            `UBTX_A_CW: n.rdata[7:0] = s.k;
            `UBTX_A_PKT: n.rdata[15:0] = s.pkt_len;
            `UBTX_A_GRANT: n.rdata[15:0] = s.grant;
            `UBTX_A_START: n.rdata = s.start_time;
            `UBTX_A_PRE: n.rdata = s.pre_pat;
            `UBTX_A_PCFG: begin
               n.rdata[`UBTX_F_PLEN] = s.pre_len;
               n.rdata[`UBTX_F_SEED] = s.seed;
            end
            `UBTX_A_STAT: begin
               n.rdata[`UBTX_S_BUSY] = (s.ph != ST_IDLE);
               n.rdata[`UBTX_S_WAIT] = (s.ph == ST_WAIT);
               n.rdata[`UBTX_S_UNDER] = s.underrun;
               n.rdata[`UBTX_S_DONE] = s.done;
               n.rdata[`UBTX_S_SPACE] = fin_ready;
            end
            `UBTX_A_DATA: ;
            `UBTX_A_TIME: n.rdata = s.now;
            default: n.rresp = `UBTX_SLVERR;
         endcase
      end
      n.arready = ~n.rvalid;

      // free timebase and symbol clock, phase held at zero until launch
      n.now = s.now + 32'h1;
      {tick, n.acc} = {1'b0, s.acc} + {1'b0, nco_inc(s.rate)};
      if (s.ph == ST_IDLE || s.ph == ST_WAIT) begin
         n.acc = '0;
         tick = 1'b0;
      end

      // symbol map, shape and emit on every symbol tick
      if (tick) begin
         n.tx_strobe = 1'b1;
         if (s.nbits != 4'h0) begin
            if (s.m16) begin
               li = lvl2(s.sh[7], s.sh[6]);
               lq = lvl2(s.sh[5], s.sh[4]);
               n.sh = {s.sh[3:0], 4'h0};
               n.nbits = s.nbits - 4'h4;
            end else begin
               li = lvl2(s.sh[7], 1'b0);
               lq = lvl2(s.sh[6], 1'b0);
               n.sh = {s.sh[5:0], 2'b00};
               n.nbits = s.nbits - 4'h2;
            end
         end else if (s.ph != ST_FLUSH && s.ph != ST_NEXT) begin
            n.underrun = 1'b1;
         end
         n.tx_i = fir(li, s.hi);
         n.tx_q = fir(lq, s.hq);
         n.hi = {s.hi[1:0], li};
         n.hq = {s.hq[1:0], lq};
      end

      // burst sequencer: preamble, then codewords of data, zero fill and parity
      take = (s.nbits == 4'h0) && (s.ph == ST_PRE || s.ph == ST_INFO || s.ph == ST_PAR);
      case (s.ph)
         ST_IDLE: n.tx_burst = 1'b0; // drops one cycle after the last strobe
         ST_WAIT: begin
            if (s.now == s.start_time) begin
               n.ph = (s.pre_len != 8'h00) ? ST_PRE : ST_NEXT;
               n.pre_cnt = s.pre_len;
               n.pre_idx = '0;
               n.lfsr = s.seed;
               n.pkt_left = s.pkt_len;
               n.grant_left = s.grant;
               n.first_cw = 1'b1;
               n.hi = '0;
               n.hq = '0;
               n.tx_burst = 1'b1;
            end
         end
         ST_PRE: begin
            if (take) begin // preamble bytes go out unscrambled
               n.sh = s.pre_pat[{s.pre_idx, 3'b000} +: 8];
               n.nbits = 4'h8;
               n.pre_idx = s.pre_idx + 2'h1;
               n.pre_cnt = s.pre_cnt - 8'h1;
               if (s.pre_cnt == 8'h01) n.ph = ST_NEXT;
            end
         end
         ST_NEXT: begin
            len = cw_len(s);
            n.first_cw = 1'b0;
            n.par = '0;
            if (len == 16'h0000) begin
               n.ph = ST_FLUSH;
               n.flush_cnt = `UBTX_FLUSH;
            end else begin
               n.ph = ST_INFO;
               n.info_left = len;
            end
         end
         ST_INFO: begin
            if (take && (s.pkt_left == 16'h0000 || fout_valid || s.underrun)) begin
               fout_ready = (s.pkt_left != 16'h0000) && fout_valid;
               d = fout_ready ? fout_data : 8'h00; // zeros after underrun too
               {n.lfsr, sb} = scr(s.lfsr, d);
               n.sh = sb;
               n.nbits = 4'h8;
               if (s.fec_en) begin
                  fb = d ^ s.par[`UBTX_NPAR-1];
                  for (int i = `UBTX_NPAR - 1; i > 0; i--)
                     n.par[i] = s.par[i-1] ^ ubtx_gf_mul(fb, GEN[i]);
                  n.par[0] = ubtx_gf_mul(fb, GEN[0]);
               end
               if (s.pkt_left != 16'h0000) n.pkt_left = s.pkt_left - 16'h1;
               if (s.grant_left != 16'h0000) n.grant_left = s.grant_left - 16'h1;
               n.info_left = s.info_left - 16'h1;
               if (s.info_left == 16'h0001) begin
                  n.ph = s.fec_en ? ST_PAR : ST_NEXT;
                  n.par_cnt = 4'(`UBTX_NPAR);
               end
            end
         end
         ST_PAR: begin
            if (take) begin
               {n.lfsr, sb} = scr(s.lfsr, s.par[`UBTX_NPAR-1]);
               n.sh = sb;
               n.nbits = 4'h8;
               n.par = {s.par[`UBTX_NPAR-2:0], 8'h00};
               n.par_cnt = s.par_cnt - 4'h1;
               if (s.par_cnt == 4'h1) n.ph = ST_NEXT;
            end
         end
         ST_FLUSH: begin
            if (tick && s.nbits == 4'h0) begin
               if (s.flush_cnt == 3'h0) begin
                  n.ph = ST_IDLE;
                  n.done = 1'b1;
               end else begin
                  n.flush_cnt = s.flush_cnt - 3'h1;
               end
            end
         end
         default: n.ph = ST_IDLE;
      endcase
   end

   // state register with reset values
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
         s.k <= `UBTX_K_RST;
         s.seed <= `UBTX_SEED_RST;
      end else begin
         s <= n;
      end
   end

   assign awready = s.awready;
   assign wready = s.wready;
   assign bvalid = s.bvalid;
   assign bresp = s.bresp;
   assign arready = s.arready;
   assign rvalid = s.rvalid;
   assign rresp = s.rresp;
   assign rdata = s.rdata;
   assign tx_i = s.tx_i;
   assign tx_q = s.tx_q;
   assign tx_strobe = s.tx_strobe;
   assign tx_burst = s.tx_burst;
endmodule
`default_nettype wire

// file: ubtx_top_properties.sv
// concurrent checks on the ports of the upstream burst transmitter
`timescale 1ns/100ps
`default_nettype none
`include "ubtx_map.svh"
module ubtx_props (
   input wire logic aclk, // clock
   input wire logic aresetn, // sync reset, low
   input wire logic [7:0] awaddr, // write address
   input wire logic awvalid, // write address valid
   input wire logic awready, // write address ready
   input wire logic wvalid, // write data valid
   input wire logic wready, // write data ready
   input wire logic [1:0] bresp, // write response
   input wire logic bvalid, // write response valid
   input wire logic bready, // write response ready
   input wire logic arvalid, // read address valid
   input wire logic arready, // read address ready
   input wire logic [31:0] rdata, // read data
   input wire logic [1:0] rresp, // read response
   input wire logic rvalid, // read data valid
   input wire logic rready, // read data ready
   input wire logic [7:0] tx_i, // shaped i sample
   input wire logic [7:0] tx_q, // shaped q sample
   input wire logic tx_strobe, // symbol pulse
   input wire logic tx_burst // burst on air
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // register bus answers
   AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped before taken");
   AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped before taken");
   AST_R_AFTER_AR: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer missing after address");
   AST_B_AFTER_W: assert property (awvalid && awready && wvalid && wready
      && awaddr != `UBTX_A_DATA |=> ##1 bvalid && !awready)
      else $error("write answer missing after address and data");
   AST_UNMAPPED_ZERO: assert property (rvalid && rresp == `UBTX_SLVERR |-> rdata == 32'h0)
      else $error("refused read returns data");
   // symbol timing and output holding
   AST_STROBE_IN_BURST: assert property (tx_strobe |-> tx_burst)
      else $error("symbol pulse outside burst");
   AST_STROBE_SPACE: assert property (tx_strobe |=> !tx_strobe [*8])
      else $error("symbols faster than highest rate");
   AST_FIRST_STROBE: assert property ($rose(tx_burst) |-> ##[1:200] tx_strobe)
      else $error("no symbol after burst start");
   AST_TX_HOLD: assert property (!tx_strobe && !$past(tx_strobe) |-> $stable(tx_i)
      && $stable(tx_q))
      else $error("samples changed between symbols");
   // main scenarios reached
   COV_BURST: cover property ($fell(tx_burst));
   COV_REFUSE: cover property (bvalid && bresp == `UBTX_SLVERR);
   COV_STROBE: cover property (tx_strobe && tx_i != 8'h00);
endmodule
bind ubtx_top ubtx_props i_ubtx_props (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
   .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready), .tx_i(tx_i), .tx_q(tx_q),
   .tx_strobe(tx_strobe), .tx_burst(tx_burst));
`default_nettype wire

// file: ubtx_rx_model.sv
// receiving end: counts symbols, measures spacing, keeps first samples
`timescale 1ns/100ps
`default_nettype none
module ubtx_rx_model (
   input wire logic aclk, // clock
   input wire logic [7:0] tx_i, // shaped i sample
   input wire logic [7:0] tx_q, // shaped q sample
   input wire logic tx_strobe, // symbol pulse
   input wire logic tx_burst // burst on air
);
   int n_sym = 0;
   int gap = 0;
   int cnt = 0;
   logic strobe_d = 1'b0;
   logic burst_d = 1'b0;
   logic [7:0] si [2];
   logic [7:0] sq [2];
   // samples are taken one cycle after the pulse so either update edge works
   always @(posedge aclk) begin
      strobe_d <= tx_strobe;
      burst_d <= tx_burst;
      cnt <= tx_strobe ? 1 : cnt + 1;
      if (tx_strobe) gap <= cnt;
      if (strobe_d && n_sym < 2) si[n_sym] <= tx_i;
      if (strobe_d && n_sym < 2) sq[n_sym] <= tx_q;
      if (tx_burst && !burst_d) n_sym <= 0;
      else if (strobe_d) n_sym <= n_sym + 1;
   end
endmodule
`default_nettype wire

// file: ubtx_tb_top.sv
// self-checking bench for the upstream burst transmitter
`timescale 1ns/100ps
`default_nettype none
`include "ubtx_map.svh"
module ubtx_tb_top;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, tx_strobe, tx_burst;
   logic [7:0] awaddr, araddr, tx_i, tx_q;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int errors = 0;
   int n_checks = 0;
   int cycles = 0;
   ubtx_top i_ubtx_top (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .tx_i(tx_i), .tx_q(tx_q), .tx_strobe(tx_strobe), .tx_burst(tx_burst));
   ubtx_rx_model i_ubtx_rx_model (.aclk(aclk), .tx_i(tx_i), .tx_q(tx_q),
      .tx_strobe(tx_strobe), .tx_burst(tx_burst));
   // 25 MHz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         close_out();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // bus write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      r = bresp;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
   // packet length, one preamble byte, then the packet bytes into the fifo
   task automatic setup(input logic [31:0] pkt, input int push);
      logic [1:0] r;
      wr(`UBTX_A_PKT, pkt, r);
      wr(`UBTX_A_PCFG, 32'h15290001, r);
      wr(`UBTX_A_PRE, 32'h000000b4, r);
      for (int i = 0; i < push; i++) wr(`UBTX_A_DATA, i + 1, r);
   endtask
   // arm at a near start time, wait out the burst, return and clear status
   task automatic launch(input logic [31:0] ctrl, output logic [31:0] s);
      logic [31:0] t;
      logic [1:0] r;
      int n;
      rd(`UBTX_A_TIME, t, r);
      wr(`UBTX_A_START, t + 32'h3c, r);
      wr(`UBTX_A_CTRL, ctrl | 32'h100, r);
      n = 0;
      while (!tx_burst && n < 200) begin
         @(posedge aclk);
         n++;
      end
      chk(tx_burst, 1);
      while (tx_burst) @(posedge aclk);
      repeat (4) @(posedge aclk);
      rd(`UBTX_A_STAT, s, r);
      wr(`UBTX_A_STAT, 32'hc, r);
   endtask
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rd(`UBTX_A_CW, d, r);
      chk(d, 32'h10);
      rd(`UBTX_A_PCFG, d, r);
      chk(d, 32'h15290000);
      rd(`UBTX_A_STAT, d, r);
      chk(d, 32'h10);
      rd(8'h28, d, r);
      chk(d, 32'h0);
      chk(r, 2'b10);
      wr(8'h28, 32'hffffffff, r);
      chk(r, 2'b10);
      wr(`UBTX_A_TIME, 32'h0, r);
      chk(r, 2'b00);
   endtask
   // each rate: preamble only, symbol spacing 25e6 / rate rounded either way
   task automatic t_rates();
      logic [31:0] s;
      int p;
      for (int idx = 0; idx < 5; idx++) begin
         setup(0, 0);
         launch(idx << 4, s);
         p = 25000000 / (160000 << idx);
         chk(i_ubtx_rx_model.gap == p || i_ubtx_rx_model.gap == p + 1, 1);
         chk(i_ubtx_rx_model.n_sym, 8);
         chk(s, 32'h18);
      end
   endtask
   // fec off: preamble 0xb4 unscrambled, filter taps 1,3,3,1, then 5 packet bytes
   task automatic t_map(input logic m16);
      logic [31:0] s;
      setup(5, 5);
      launch({m16, 2'b00} | 32'h40, s);
      chk(i_ubtx_rx_model.n_sym, m16 ? 16 : 28);
      chk(i_ubtx_rx_model.si[0], 32'hfd);
      chk(i_ubtx_rx_model.si[1], m16 ? 32'hf8 : 32'hf4);
      chk(i_ubtx_rx_model.sq[0], m16 ? 32'hff : 32'h03);
      chk(i_ubtx_rx_model.sq[1], m16 ? 32'h00 : 32'h06);
      chk(s, 32'h18);
   endtask
   // k = 20, grant 56: fixed gives 2 codewords, shortened adds one of 16
   task automatic t_cw(input logic [31:0] ctrl, input int syms);
      logic [31:0] s;
      logic [1:0] r;
      wr(`UBTX_A_CW, 32'h14, r);
      wr(`UBTX_A_GRANT, 32'h38, r);
      setup(17, 17);
      rd(`UBTX_A_STAT, s, r);
      chk(s[4], 0);
      launch(ctrl | 32'h40, s);
      chk(i_ubtx_rx_model.n_sym, syms);
      chk(s, 32'h18);
   endtask
   task automatic t_under();
      logic [31:0] s;
      logic [1:0] r;
      setup(3, 1);
      launch(32'h40, s);
      chk(s, 32'h1c);
      rd(`UBTX_A_STAT, s, r);
      chk(s, 32'h10);
   endtask
   // reset, then the scenarios
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      bready = 1'b1;
      rready = 1'b1;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_rates();
      t_map(1'b0);
      t_map(1'b1);
      t_cw(32'h1, 232);
      t_cw(32'h3, 328);
      t_under();
      close_out();
   end
endmodule
`default_nettype wire
